// File: plc_pkg.sv
// constants, field layout and state types for the link configuration block
package plc_pkg;

   // ************************************************
   // structure
   // ************************************************
   localparam int PORTS = 2;               // two phy ports
   localparam int DATA_W = 16;             // register data width
   localparam int ADDR_W = 4;              // register address width
   localparam int SEED_W = 8;              // role tie-break seed width

   // ************************************************
   // register map: address = {1'b0, port, reg}
   // ************************************************
   localparam logic [1:0] REG_CTRL = 2'h0; // negotiation control
   localparam logic [1:0] REG_ADV = 2'h1;  // local advertisement
   localparam logic [1:0] REG_STAT = 2'h2; // status, read only

   // control register fields
   localparam int CTRL_AN_EN_BIT = 0;      // negotiation enable
   localparam int CTRL_RESTART_BIT = 1;    // restart, self clearing
   localparam int CTRL_ROLE_BIT = 2;       // role preference config

   // advertisement register fields
   localparam int ADV_ABL_BIT = 0;         // high level ability
   localparam int ADV_REQ_BIT = 1;         // high level request
   localparam int ADV_MST_BIT = 2;         // advertised role master

   // status register fields
   localparam int STAT_DONE_BIT = 0;       // negotiation done
   localparam int STAT_P_ABL_BIT = 1;      // partner ability
   localparam int STAT_P_REQ_BIT = 2;      // partner request
   localparam int STAT_P_MST_BIT = 3;      // partner role master
   localparam int STAT_HI_ABLE_BIT = 4;    // read-only strap ability
   localparam int STAT_TX_AMP_BIT = 5;     // amplitude in use
   localparam int STAT_ROLE_BIT = 6;       // role in use

   // ************************************************
   // reset values
   // ************************************************
   localparam logic AN_EN_RESET = 1'b1;    // negotiation on at reset
   localparam logic [PORTS-1:0] ROLE_RESET = 2'h1; // port 1 master
   localparam logic [2:0] STRAP_SETTLE = 3'h4; // cycles before defaults
   localparam logic [SEED_W-1:0] SEED_RESET = 8'h5A; // nonzero lfsr

   // negotiation sequencer states
   typedef enum logic [1:0] {AN_OFF, AN_SEND, AN_DONE} plc_an_state_e;

endpackage

// File: plc_strap_if.sv
// carrier between the top and the strap pin synchroniser
interface plc_strap_if;
   logic raw;     // strap pin as it arrives
   logic level;   // filtered, synchronised level
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface

// File: plc_strap_sync.sv
// three flop synchroniser and agreement filter for one strap pin
module plc_strap_sync
   import plc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   plc_strap_if.sync strap
);

   // ************************************************
   // state
   // ************************************************
   logic s1_q, s2_q, s3_q, lvl_q;  // chain and accepted level
   logic s1_d, s2_d, s3_d, lvl_d;

   // next values: the first stage feeds only the second
   always_comb
   begin
      s1_d = strap.raw;
      s2_d = s1_q;
      s3_d = s2_q;
      lvl_d = lvl_q;
      // a change counts once stages two and three agree
      if (s2_q == s3_q)
      begin
         lvl_d = s3_q;
      end
   end

   // registers; low is the pulled-down, unconnected pin level
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign strap.level = lvl_q;

endmodule

// File: plc_link_cfg.sv
// per-port amplitude, role and negotiation control for a two-port phy
module plc_link_cfg
   import plc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   input wire logic PORT1_HIGH_AMPLITUDE_STRAP_N_I,
   input wire logic PORT2_HIGH_AMPLITUDE_STRAP_N_I,
   input wire logic [PORTS-1:0] LINK_UP_I,
   input wire logic [PORTS-1:0] PAGE_RX_VALID_I,
   input wire logic [PORTS-1:0] PAGE_RX_ABILITY_I,
   input wire logic [PORTS-1:0] PAGE_RX_REQUEST_I,
   input wire logic [PORTS-1:0] PAGE_RX_MASTER_I,
   input wire logic [PORTS*SEED_W-1:0] PAGE_RX_SEED_I,
   output logic [PORTS-1:0] PAGE_TX_VALID_O,
   output logic [PORTS-1:0] PAGE_TX_ABILITY_O,
   output logic [PORTS-1:0] PAGE_TX_REQUEST_O,
   output logic [PORTS-1:0] PAGE_TX_MASTER_O,
   output logic [PORTS*SEED_W-1:0] PAGE_TX_SEED_O,
   output logic [PORTS-1:0] NEGOTIATION_DONE_O,
   output logic [PORTS-1:0] TX_AMPLITUDE_SELECT_O,
   output logic [PORTS-1:0] ROLE_MASTER_O
);

   // ************************************************
   // address decode
   // ************************************************

   // register address of one port's register
   function automatic logic [ADDR_W-1:0] reg_addr(input int port,
                                                  input logic [1:0] sel);
      logic [ADDR_W-1:0] a;
      a = {1'b0, port[0], sel};
      return a;
   endfunction

   // ************************************************
   // strap pins
   // ************************************************
   plc_strap_if strap_p1 ();   // port 1 strap carrier
   plc_strap_if strap_p2 ();   // port 2 strap carrier
   logic [PORTS-1:0] strap_lvl; // synchronised strap levels

   assign strap_p1.raw = PORT1_HIGH_AMPLITUDE_STRAP_N_I;
   assign strap_p2.raw = PORT2_HIGH_AMPLITUDE_STRAP_N_I;
   assign strap_lvl = {strap_p2.level, strap_p1.level};

   // pins arrive from the board, outside the clock domain
   plc_strap_sync u_sync_p1 (
      .CLK_I (CLK_I),
      .RST_I (RST_I),
      .strap (strap_p1.sync)
   );

   plc_strap_sync u_sync_p2 (
      .CLK_I (CLK_I),
      .RST_I (RST_I),
      .strap (strap_p2.sync)
   );

   // ************************************************
   // default loading and seed source
   // ************************************************
   logic [2:0] init_cnt_q, init_cnt_d;  // settle counter
   logic init_done_q, init_done_d;       // defaults loaded
   logic load_defaults;                  // one-cycle load pulse
   logic [SEED_W-1:0] lfsr_q, lfsr_d;    // free running seed source

   // wait for the synchroniser to settle, then load defaults once;
   // the strap is caught after reset release, never under reset
   always_comb
   begin
      init_cnt_d = init_cnt_q;
      init_done_d = init_done_q;
      load_defaults = 1'b0;
      if (!init_done_q)
      begin
         if (init_cnt_q == STRAP_SETTLE)
         begin
            load_defaults = 1'b1;
            init_done_d = 1'b1;
         end
         else
         begin
            init_cnt_d = init_cnt_q + 3'h1;
         end
      end
      // maximal length taps keep the seed from sticking at zero
      lfsr_d = {lfsr_q[SEED_W-2:0],
                lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
   end

   // registers of the shared logic
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         init_cnt_q <= 3'h0;
         init_done_q <= 1'b0;
         lfsr_q <= SEED_RESET;
      end
      else
      begin
         init_cnt_q <= init_cnt_d;
         init_done_q <= init_done_d;
         lfsr_q <= lfsr_d;
      end
   end

   // ************************************************
   // per-port negotiation
   // ************************************************
   logic [DATA_W-1:0] port_rd [PORTS]; // per-port read word

   genvar p;
   generate
      for (p = 0; p < PORTS; p++)
      begin : g_port
         // control and advertisement
         logic an_en_q, an_en_d;           // negotiation enable
         logic role_cfg_q, role_cfg_d;     // role preference config
         logic adv_abl_q, adv_abl_d;       // advertised ability
         logic adv_req_q, adv_req_d;       // advertised request
         logic adv_mst_q, adv_mst_d;       // advertised role
         // negotiation state
         plc_an_state_e st_q, st_d;        // sequencer state
         logic done_q, done_d;             // negotiation done
         logic p_abl_q, p_abl_d;           // partner ability
         logic p_req_q, p_req_d;           // partner request
         logic p_mst_q, p_mst_d;           // partner role
         logic [SEED_W-1:0] seed_q, seed_d; // local tie-break seed
         logic res_hi_q, res_hi_d;         // resolved amplitude
         logic tx_amp_q, tx_amp_d;         // amplitude to the driver
         logic page_vld_q, page_vld_d;     // page being offered
         logic link_q, link_d;             // link level last cycle
         // helpers
         logic hi_en;                      // high-level mode active
         logic wr_ctrl, wr_adv;            // register write hits
         logic restart, link_drop;         // restart causes
         logic [SEED_W-1:0] rx_seed;       // partner seed
         logic role_win;                   // local side takes master
         logic role_tie;                   // arbitration undecided

         // strap low (pull-down) selects high-level mode
         assign hi_en = ~strap_lvl[p];
         assign rx_seed = PAGE_RX_SEED_I[p*SEED_W +: SEED_W];

         // arbitration and next values of one port
         always_comb
         begin
            wr_ctrl = WR_I && (ADDR_I == reg_addr(p, REG_CTRL));
            wr_adv = WR_I && (ADDR_I == reg_addr(p, REG_ADV));
            restart = wr_ctrl && WDATA_I[CTRL_RESTART_BIT];
            link_drop = link_q && !LINK_UP_I[p];
            // differing preferences settle it; else higher seed leads
            role_tie = 1'b0;
            if (adv_mst_q != PAGE_RX_MASTER_I[p])
            begin
               role_win = adv_mst_q;
            end
            else
            begin
               role_win = (seed_q > rx_seed);
               role_tie = (seed_q == rx_seed);
            end
            an_en_d = an_en_q;
            role_cfg_d = role_cfg_q;
            adv_abl_d = adv_abl_q;
            adv_req_d = adv_req_q;
            adv_mst_d = adv_mst_q;
            st_d = st_q;
            done_d = done_q;
            p_abl_d = p_abl_q;
            p_req_d = p_req_q;
            p_mst_d = p_mst_q;
            seed_d = seed_q;
            res_hi_d = res_hi_q;
            link_d = LINK_UP_I[p];
            // software writes of control and advertisement
            if (wr_ctrl)
            begin
               an_en_d = WDATA_I[CTRL_AN_EN_BIT];
               role_cfg_d = WDATA_I[CTRL_ROLE_BIT];
            end
            if (load_defaults)
            begin
               adv_abl_d = hi_en;
               adv_req_d = hi_en;
            end
            else if (wr_adv)
            begin
               adv_mst_d = WDATA_I[ADV_MST_BIT];
               // level bits are locked in low-only mode
               if (hi_en)
               begin
                  adv_abl_d = WDATA_I[ADV_ABL_BIT];
                  adv_req_d = WDATA_I[ADV_REQ_BIT];
               end
            end
            // a low-only port stops advertising the high level once its strap level settles
            if (!hi_en)
            begin
               adv_abl_d = 1'b0;
               adv_req_d = 1'b0;
            end
            // sequencer
            case (st_q)
               AN_OFF:
               begin
                  done_d = 1'b0;
                  if (an_en_d)
                  begin
                     st_d = AN_SEND;
                     seed_d = lfsr_q;
                  end
               end
               AN_SEND:
               begin
                  if (!an_en_d)
                  begin
                     st_d = AN_OFF;
                  end
                  else if (restart)
                  begin
                     seed_d = lfsr_q;
                  end
                  else if (PAGE_RX_VALID_I[p])
                  begin
                     // capture partner page, compare, elect
                     p_abl_d = PAGE_RX_ABILITY_I[p];
                     p_req_d = PAGE_RX_REQUEST_I[p];
                     p_mst_d = PAGE_RX_MASTER_I[p];
                     res_hi_d = adv_abl_q && PAGE_RX_ABILITY_I[p] &&
                        (adv_req_q || PAGE_RX_REQUEST_I[p]);
                     if (role_tie)
                     begin
                        // equal seeds: offer a fresh page
                        seed_d = lfsr_q;
                     end
                     else
                     begin
                        st_d = AN_DONE;
                        done_d = 1'b1;
                        role_cfg_d = role_win;
                     end
                  end
               end
               AN_DONE:
               begin
                  if (!an_en_d)
                  begin
                     st_d = AN_OFF;
                  end
                  else if (restart || link_drop)
                  begin
                     // restart without software on link loss
                     st_d = AN_SEND;
                     done_d = 1'b0;
                     seed_d = lfsr_q;
                  end
               end
               default:
               begin
                  st_d = AN_OFF;
               end
            endcase
            // disabled: fixed by strap and request; enabled: resolved
            if (an_en_d)
            begin
               tx_amp_d = done_d && res_hi_d;
            end
            else
            begin
               tx_amp_d = hi_en && adv_req_d;
            end
            page_vld_d = (st_d == AN_SEND);
         end

         // registers of one port
         always_ff @(posedge CLK_I)
         begin
            if (RST_I)
            begin
               an_en_q <= AN_EN_RESET;
               role_cfg_q <= ROLE_RESET[p];
               adv_mst_q <= ROLE_RESET[p];
               adv_abl_q <= 1'b1;
               adv_req_q <= 1'b1;
               st_q <= AN_OFF;
               done_q <= 1'b0;
               p_abl_q <= 1'b0;
               p_req_q <= 1'b0;
               p_mst_q <= 1'b0;
               seed_q <= SEED_RESET;
               res_hi_q <= 1'b0;
               tx_amp_q <= 1'b0;
               page_vld_q <= 1'b0;
               link_q <= 1'b0;
            end
            else
            begin
               an_en_q <= an_en_d;
               role_cfg_q <= role_cfg_d;
               adv_mst_q <= adv_mst_d;
               adv_abl_q <= adv_abl_d;
               adv_req_q <= adv_req_d;
               st_q <= st_d;
               done_q <= done_d;
               p_abl_q <= p_abl_d;
               p_req_q <= p_req_d;
               p_mst_q <= p_mst_d;
               seed_q <= seed_d;
               res_hi_q <= res_hi_d;
               tx_amp_q <= tx_amp_d;
               page_vld_q <= page_vld_d;
               link_q <= link_d;
            end
         end

         // outputs straight from flops
         assign PAGE_TX_VALID_O[p] = page_vld_q;
         assign PAGE_TX_ABILITY_O[p] = adv_abl_q;
         assign PAGE_TX_REQUEST_O[p] = adv_req_q;
         assign PAGE_TX_MASTER_O[p] = adv_mst_q;
         assign PAGE_TX_SEED_O[p*SEED_W +: SEED_W] = seed_q;
         assign NEGOTIATION_DONE_O[p] = done_q;
         assign TX_AMPLITUDE_SELECT_O[p] = tx_amp_q;
         assign ROLE_MASTER_O[p] = role_cfg_q;

         // read word of the port selected by the address
         always_comb
         begin
            port_rd[p] = '0;
            if (ADDR_I == reg_addr(p, REG_CTRL))
            begin
               // restart reads back as zero, it only pulses
               port_rd[p][CTRL_AN_EN_BIT] = an_en_q;
               port_rd[p][CTRL_ROLE_BIT] = role_cfg_q;
            end
            else if (ADDR_I == reg_addr(p, REG_ADV))
            begin
               port_rd[p][ADV_ABL_BIT] = adv_abl_q;
               port_rd[p][ADV_REQ_BIT] = adv_req_q;
               port_rd[p][ADV_MST_BIT] = adv_mst_q;
            end
            else if (ADDR_I == reg_addr(p, REG_STAT))
            begin
               port_rd[p][STAT_DONE_BIT] = done_q;
               port_rd[p][STAT_P_ABL_BIT] = p_abl_q;
               port_rd[p][STAT_P_REQ_BIT] = p_req_q;
               port_rd[p][STAT_P_MST_BIT] = p_mst_q;
               port_rd[p][STAT_HI_ABLE_BIT] = hi_en;
               port_rd[p][STAT_TX_AMP_BIT] = tx_amp_q;
               port_rd[p][STAT_ROLE_BIT] = role_cfg_q;
            end
         end
      end
   endgenerate

   // ************************************************
   // register read port
   // ************************************************
   logic [DATA_W-1:0] rdata_q, rdata_d; // read data, one cycle late

   // unmapped addresses read zero; data stand for one cycle only
   always_comb
   begin
      rdata_d = '0;
      if (RD_I)
      begin
         rdata_d = port_rd[0] | port_rd[1];
      end
   end

   // read data register
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;

endmodule

// File: plc_link_cfg_checker.sv
// port 1 negotiation and register bus assertions for the link block
module plc_link_cfg_checker
   import plc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [DATA_W-1:0] RDATA_O,
   input wire logic [PORTS-1:0] LINK_UP_I,
   input wire logic [PORTS-1:0] PAGE_RX_VALID_I,
   input wire logic [PORTS-1:0] PAGE_RX_ABILITY_I,
   input wire logic [PORTS-1:0] PAGE_RX_REQUEST_I,
   input wire logic [PORTS-1:0] PAGE_RX_MASTER_I,
   input wire logic [PORTS-1:0] PAGE_TX_VALID_O,
   input wire logic [PORTS-1:0] PAGE_TX_ABILITY_O,
   input wire logic [PORTS-1:0] PAGE_TX_REQUEST_O,
   input wire logic [PORTS-1:0] PAGE_TX_MASTER_O,
   input wire logic [PORTS-1:0] NEGOTIATION_DONE_O,
   input wire logic [PORTS-1:0] TX_AMPLITUDE_SELECT_O,
   input wire logic [PORTS-1:0] ROLE_MASTER_O
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********************************************
   // properties on port 1 and the read bus, plus reset checks on both ports
   // ********************************************
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   logic take;    // page taken while our own page is on offer
   logic differ;  // taken page whose role differs from ours
   logic want_hi; // both able and at least one asks for high level
   assign take = PAGE_RX_VALID_I[0] && PAGE_TX_VALID_O[0];
   assign differ = take && (PAGE_RX_MASTER_I[0] != PAGE_TX_MASTER_O[0]);
   assign want_hi = PAGE_TX_ABILITY_O[0] && PAGE_RX_ABILITY_I[0] &&
      (PAGE_TX_REQUEST_O[0] || PAGE_RX_REQUEST_I[0]);
   property p_amp;
      take |=> !NEGOTIATION_DONE_O[0] ||
         TX_AMPLITUDE_SELECT_O[0] == $past(want_hi);
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude mismatch");
   property p_done;
      differ |=> NEGOTIATION_DONE_O[0] && !PAGE_TX_VALID_O[0];
   endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_role;
      differ |=> ROLE_MASTER_O[0] == $past(PAGE_TX_MASTER_O[0]);
   endproperty
   a_role: assert property (p_role) else $error("role mismatch");
   property p_link;
      $fell(LINK_UP_I[0]) && NEGOTIATION_DONE_O[0] |->
         ##[1:3] (PAGE_TX_VALID_O[0] && !NEGOTIATION_DONE_O[0]);
   endproperty
   a_link: assert property (p_link) else $error("no relink");
   property p_restart;
      WR_I && ADDR_I == 4'h0 && WDATA_I[1:0] == 2'h3 && NEGOTIATION_DONE_O[0]
         |-> ##[1:4] (PAGE_TX_VALID_O[0] && !NEGOTIATION_DONE_O[0]);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   property p_role_rst;
      $fell(RST_I) |-> ROLE_MASTER_O == 2'h1 && PAGE_TX_MASTER_O == 2'h1;
   endproperty
   a_role_rst: assert property (p_role_rst) else $error("role reset");
   property p_an_default;
      $fell(RST_I) |-> ##[1:3] PAGE_TX_VALID_O == 2'h3;
   endproperty
   a_an_default: assert property (p_an_default) else $error("an off");
   property p_done_hold;
      NEGOTIATION_DONE_O[0] && LINK_UP_I[0] && $past(LINK_UP_I[0]) && !WR_I
         && !$past(WR_I) && !$past(WR_I, 2) |=> NEGOTIATION_DONE_O[0];
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done lost");
   property p_rd_quiet;
      !RD_I |=> RDATA_O == 16'h0000;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data idle");
   c_page: cover property (differ);
   c_link: cover property ($fell(LINK_UP_I[0]) && NEGOTIATION_DONE_O[0]);
   c_restart: cover property (WR_I && ADDR_I == 4'h0 && WDATA_I[1]);
endmodule

bind plc_link_cfg plc_link_cfg_checker chk (.CLK_I(CLK_I), .RST_I(RST_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .LINK_UP_I(LINK_UP_I),
   .PAGE_RX_VALID_I(PAGE_RX_VALID_I), .PAGE_RX_ABILITY_I(PAGE_RX_ABILITY_I),
   .PAGE_RX_REQUEST_I(PAGE_RX_REQUEST_I), .PAGE_RX_MASTER_I(PAGE_RX_MASTER_I),
   .PAGE_TX_VALID_O(PAGE_TX_VALID_O), .PAGE_TX_ABILITY_O(PAGE_TX_ABILITY_O),
   .PAGE_TX_REQUEST_O(PAGE_TX_REQUEST_O), .PAGE_TX_MASTER_O(PAGE_TX_MASTER_O),
   .NEGOTIATION_DONE_O(NEGOTIATION_DONE_O),
   .TX_AMPLITUDE_SELECT_O(TX_AMPLITUDE_SELECT_O),
   .ROLE_MASTER_O(ROLE_MASTER_O));

// File: plc_partner.sv
// behavioural far-end phy: answers each offered page after a set delay
module plc_partner
   import plc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic offer_i,
   input wire logic abl_i,
   input wire logic req_i,
   input wire logic mst_i,
   input wire logic [SEED_W-1:0] seed_i,
   input wire logic [3:0] wait_i,
   output logic valid_o,
   output logic abl_o,
   output logic req_o,
   output logic mst_o,
   output logic [SEED_W-1:0] seed_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********************************************
   // page answer
   // ********************************************
   logic [3:0] cnt; // cycles since the offer appeared
   logic sent;      // one page per offer, a fresh offer rearms
   // wait_i of 0 answers promptly, larger values model a slow partner
   always @(posedge clk_i)
   begin
      if (rst_i || !offer_i)
      begin
         cnt <= 4'h0;
         sent <= 1'b0;
         valid_o <= 1'b0;
      end
      else if (!sent && cnt == wait_i)
      begin
         sent <= 1'b1;
         valid_o <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 4'h1;
         valid_o <= 1'b0;
      end
   end
   // fields hold only with the pulse; the inverse elsewhere exposes late use
   assign abl_o = valid_o ? abl_i : !abl_i;
   assign req_o = valid_o ? req_i : !req_i;
   assign mst_o = valid_o ? mst_i : !mst_i;
   assign seed_o = valid_o ? seed_i : ~seed_i;
endmodule

// File: plc_link_cfg_test.sv
// self-checking bench for the link configuration block
module plc_link_cfg_test
   import plc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic strap1_n; // low selects high-level mode
   logic strap2_n;
   logic [PORTS-1:0] link_up;
   logic [PORTS-1:0] p_abl; // partner page fields per port
   logic [PORTS-1:0] p_req;
   logic [PORTS-1:0] p_mst;
   logic [3:0] p_wait;
   logic hi; // expected amplitude
   int k;
   int cycles = 0;
   int mismatches = 0;
   int n_compared = 0;
   wire logic [DATA_W-1:0] rdata;
   wire logic [PORTS-1:0] rx_v, rx_a, rx_r, rx_m, tx_v, done, amp, role;
   wire logic [PORTS*SEED_W-1:0] rx_s;
   // ********************************************
   // design and far-end partners
   // ********************************************
   always #50 clk = ~clk;
   plc_link_cfg dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_stb), .RD_I(rd_stb), .RDATA_O(rdata),
      .PORT1_HIGH_AMPLITUDE_STRAP_N_I(strap1_n),
      .PORT2_HIGH_AMPLITUDE_STRAP_N_I(strap2_n), .LINK_UP_I(link_up),
      .PAGE_RX_VALID_I(rx_v), .PAGE_RX_ABILITY_I(rx_a),
      .PAGE_RX_REQUEST_I(rx_r), .PAGE_RX_MASTER_I(rx_m),
      .PAGE_RX_SEED_I(rx_s), .PAGE_TX_VALID_O(tx_v), .PAGE_TX_ABILITY_O(),
      .PAGE_TX_REQUEST_O(), .PAGE_TX_MASTER_O(), .PAGE_TX_SEED_O(),
      .NEGOTIATION_DONE_O(done), .TX_AMPLITUDE_SELECT_O(amp),
      .ROLE_MASTER_O(role));
   for (genvar g = 0; g < PORTS; g++)
   begin : g_lp
      plc_partner lp (.clk_i(clk), .rst_i(rst), .offer_i(tx_v[g]),
         .abl_i(p_abl[g]), .req_i(p_req[g]), .mst_i(p_mst[g]),
         .seed_i(8'h3C), .wait_i(p_wait), .valid_o(rx_v[g]),
         .abl_o(rx_a[g]), .req_o(rx_r[g]), .mst_o(rx_m[g]),
         .seed_o(rx_s[g*SEED_W +: SEED_W]));
   end
   task automatic chk(input string n, input logic [DATA_W-1:0] e,
      input logic [DATA_W-1:0] g);
      begin
         n_compared++;
         if (g !== e)
         begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   // strobes drop one edge before the next task may raise them again
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr_stb <= 1'b1;
         @(posedge clk);
         wr_stb <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      begin
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge clk);
         rd_stb <= 1'b0;
         #1;
         chk("read data", e, rdata);
         @(posedge clk);
      end
   endtask
   // bounded wait for port p to finish negotiating
   task automatic wait_done(input int p);
      int n;
      begin
         repeat (3) @(posedge clk);
         for (n = 0; n < 60 && done[p] !== 1'b1; n++)
            @(posedge clk);
         #1;
         chk("done", 16'h0001, 16'(done[p]));
      end
   endtask
   task automatic end_of_test();
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // a hang counts as a mismatch; a full run needs well under 1000 cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   initial
   begin
      rst = 1'b1;
      addr = 4'h0;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      strap1_n = 1'b0; // pulled-down pin: high-level mode
      strap2_n = 1'b1; // low amplitude only
      link_up = 2'h3;
      p_abl = 2'h3;
      p_req = 2'h2;
      p_mst = 2'h2;
      p_wait = 4'hA; // slow, so strap defaults load before the page
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (40) @(posedge clk);
      rd(4'h1, 16'h0007);
      rd(4'h5, 16'h0000);
      rd(4'h0, 16'h0005);
      rd(4'h4, 16'h0001);
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h0073);
      rd(4'h6, 16'h000F);
      chk("role", 16'h0001, 16'(role));
      wr(4'h5, 16'h0003);
      rd(4'h5, 16'h0000);
      wr(4'h8, 16'hFFFF);
      rd(4'h8, 16'h0000);
      rd(4'h3, 16'h0000);
      $display("test defaults done");
      p_wait <= 4'h4;
      for (k = 0; k < 16; k++)
      begin
         hi = k[0] & k[2] & (k[1] | k[3]);
         p_abl[0] <= k[2];
         p_req[0] <= k[3];
         wr(4'h1, {13'h0000, 1'b1, k[1], k[0]});
         wr(4'h0, 16'h0003);
         wait_done(0);
         chk("amplitude", 16'(hi), 16'(amp[0]));
         rd(4'h2, {9'h000, 1'b1, hi, 2'h2, k[3], k[2], 1'b1});
      end
      $display("test resolution done");
      wr(4'h0, 16'h0004);
      repeat (3) @(posedge clk);
      #1;
      chk("role", 16'h0001, 16'(role[0]));
      chk("amplitude", 16'h0001, 16'(amp[0]));
      wr(4'h0, 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      chk("role", 16'h0000, 16'(role[0]));
      wr(4'h0, 16'h0001);
      wait_done(0);
      rd(4'h0, 16'h0005);
      $display("test disable done");
      link_up <= 2'h2;
      repeat (2) @(posedge clk);
      #1;
      chk("done", 16'h0000, 16'(done[0]));
      @(posedge clk);
      link_up <= 2'h3;
      wait_done(0);
      $display("test link loss done");
      end_of_test();
   end
endmodule
